// *** rtl/tgce_evt_if.sv ***
// Event and control wires between the gate core and its timers.
// Assumes all three ends run on the one system clock.
`timescale 1ns/1ps
`default_nettype none
interface tgce_evt_if;
   logic       wdt_run;
   logic       wdt_clr;
   logic       wdt_psa;
   logic [2:0] wdt_ps;
   logic       wdt_ovf;
   logic       per_tick;
   logic       per_wr;
   logic [7:0] per_wdata;
   logic [7:0] per_limit;
   logic [7:0] per_count;
   logic       per_match;

   modport core (output wdt_run, wdt_clr, wdt_psa, wdt_ps, per_tick,
                 per_wr, per_wdata, per_limit,
                 input  wdt_ovf, per_count, per_match);
   modport wdt  (input  wdt_run, wdt_clr, wdt_psa, wdt_ps,
                 output wdt_ovf);
   modport per  (input  per_tick, per_wr, per_wdata, per_limit,
                 output per_count, per_match);
endinterface
`default_nettype wire

// *** rtl/tgce_gate.sv ***
// Gate-controlled event counter with companion, period and watchdog
// gate sources, reached over a simple strobe register port.
// Assumes all inputs are synchronous to sys_clk; ticks are one-cycle.
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module tgce_gate
   import tgce_pkg::*;
#(
   parameter int CNT_W   = CNT_W_DEF,
   parameter int OSC_DIV = WDT_OSC_DIV
) (
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_strobe,
   input  wire logic              rd_strobe,
   output logic      [DATA_W-1:0] rd_data,
   input  wire logic              gate_input_pin,
   input  wire logic              counter_clock_source,
   input  wire logic              companion_tick,
   input  wire logic              period_tick,
   input  wire logic              watchdog_clear_op,
   input  wire logic              sleep_enter,
   input  wire logic              sleep_wake,
   input  wire logic              wdt_config_en,
   output logic                   gate_value,
   output logic                   wdt_reset_req,
   output logic                   wdt_wake_req
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic              gate_en;
      logic              gate_pol;
      logic              gate_tog;
      tgce_src_t         gate_sel;
      logic              cnt_on;
      logic [CNT_W-1:0]  count;
      logic [7:0]        comp;
      logic              comp_ovf;
      logic [7:0]        per_lim;
      logic              prescaler_assign_bit;
      logic [2:0]        ps;
      logic              adj_prev;
      logic              tog;
      logic              active;
      logic              sleeping;
      logic              rst_req;
      logic              wake_req;
      logic [DATA_W-1:0] rdata;
   } tgce_state_t;

   localparam tgce_state_t RST_STATE = '{
      gate_sel : SRC_PIN,
      per_lim  : PER_LIM_RST,
      prescaler_assign_bit      : OPT_PSA_RST,
      ps       : OPT_PS_RST,
      default  : '0
   };

   tgce_state_t r_reg, r_next;
   tgce_evt_if  ev ();

   logic src_raw;
   logic src_adj;
   logic src_rise;
   logic gate_open;
   logic cnt_inc;
   logic wr_hit;

   function automatic logic [DATA_W-1:0] tgce_zext8(
      input logic [7:0] v
   );
      tgce_zext8 = {{(DATA_W-8){1'b0}}, v};
   endfunction

   // ------------------------------------------------------------
   // Timers behind the gate
   // ------------------------------------------------------------
   tgce_wdt #(
      .OSC_DIV (OSC_DIV),
      .BASE_W  (WDT_BASE_W)
   ) u_wdt (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .ev      (ev.wdt)
   );

   tgce_period u_period (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .ev      (ev.per)
   );

   assign ev.wdt_run   = wdt_config_en ||
                         (r_reg.gate_en && r_reg.gate_sel == SRC_WDT);
   assign ev.wdt_clr   = watchdog_clear_op || sleep_enter ||
                         sleep_wake || r_reg.wake_req;
   assign ev.wdt_psa   = r_reg.prescaler_assign_bit;
   assign ev.wdt_ps    = r_reg.ps;
   assign ev.per_tick  = period_tick;
   assign ev.per_limit = r_reg.per_lim;
   assign ev.per_wr    = wr_strobe && addr == OFS_PER_CNT;
   assign ev.per_wdata = wr_data[7:0];

   // ------------------------------------------------------------
   // Gate path
   // ------------------------------------------------------------
   always_comb begin
      case (r_reg.gate_sel)
         SRC_PIN:  src_raw = gate_input_pin;
         SRC_COMP: src_raw = r_reg.comp_ovf;
         SRC_PER:  src_raw = ev.per_match;
         SRC_WDT:  src_raw = ev.wdt_ovf;
         default:  src_raw = 1'b0;
      endcase
   end

   assign src_adj   = (src_raw == r_reg.gate_pol);
   assign src_rise  = src_adj && !r_reg.adj_prev;
   assign gate_open = r_reg.gate_tog ? r_reg.tog : src_adj;
   assign cnt_inc   = r_reg.cnt_on && counter_clock_source &&
                      (!r_reg.gate_en || gate_open);
   assign wr_hit    = wr_strobe;

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      r_next          = r_reg;
      r_next.rdata    = '0;
      r_next.comp_ovf = 1'b0;
      r_next.rst_req  = 1'b0;
      r_next.wake_req = 1'b0;
      r_next.adj_prev = src_adj;
      r_next.active   = gate_open;

      if (!r_reg.gate_tog) begin
         r_next.tog = 1'b0;
      end else if (src_rise) begin
         r_next.tog = !r_reg.tog;
      end

      if (cnt_inc) begin
         r_next.count = CNT_W'(r_reg.count + 1'b1);
      end

      if (companion_tick) begin
         r_next.comp     = r_reg.comp + 8'h01;
         r_next.comp_ovf = (r_reg.comp == COMP_MAX);
      end

      // Sleep tracking for wake requests
      if (sleep_enter) begin
         r_next.sleeping = 1'b1;
      end else if (sleep_wake || r_reg.wake_req) begin
         r_next.sleeping = 1'b0;
      end

      if (ev.wdt_ovf && wdt_config_en) begin
         r_next.rst_req  = !r_reg.sleeping;
         r_next.wake_req = r_reg.sleeping;
      end

      // Software writes win over same-cycle counting
      if (wr_hit) begin
         case (addr)
            OFS_GATE_CTRL: begin
               r_next.gate_en  = wr_data[GC_EN_BIT];
               r_next.gate_pol = wr_data[GC_POL_BIT];
               r_next.gate_tog = wr_data[GC_TOG_BIT];
               r_next.gate_sel = tgce_src_t'(wr_data[GC_SEL_LO +: 2]);
            end
            OFS_CNT_CTRL: r_next.cnt_on  = wr_data[CC_ON_BIT];
            OFS_COUNT:    r_next.count   = wr_data[CNT_W-1:0];
            OFS_COMP: begin
               r_next.comp     = wr_data[7:0];
               r_next.comp_ovf = 1'b0;
            end
            OFS_PER_LIM:  r_next.per_lim = wr_data[7:0];
            OFS_OPTION: begin
               r_next.prescaler_assign_bit = wr_data[OPT_PSA_BIT];
               r_next.ps  = wr_data[OPT_PS_LO +: 3];
            end
            default: ;
         endcase
      end

      if (rd_strobe) begin
         case (addr)
            OFS_GATE_CTRL: begin
               r_next.rdata[GC_EN_BIT]      = r_reg.gate_en;
               r_next.rdata[GC_POL_BIT]     = r_reg.gate_pol;
               r_next.rdata[GC_TOG_BIT]     = r_reg.gate_tog;
               r_next.rdata[GC_VAL_BIT]     = r_reg.active;
               r_next.rdata[GC_SEL_LO +: 2] = r_reg.gate_sel;
            end
            OFS_CNT_CTRL: r_next.rdata[CC_ON_BIT] = r_reg.cnt_on;
            OFS_COUNT:    r_next.rdata[CNT_W-1:0] = r_reg.count;
            OFS_COMP:     r_next.rdata = tgce_zext8(r_reg.comp);
            OFS_PER_CNT:  r_next.rdata = tgce_zext8(ev.per_count);
            OFS_PER_LIM:  r_next.rdata = tgce_zext8(r_reg.per_lim);
            OFS_OPTION: begin
               r_next.rdata[OPT_PSA_BIT]    = r_reg.prescaler_assign_bit;
               r_next.rdata[OPT_PS_LO +: 3] = r_reg.ps;
            end
            OFS_STATUS: begin
               r_next.rdata[ST_RUN_BIT] = ev.wdt_run;
               r_next.rdata[ST_SLP_BIT] = r_reg.sleeping;
            end
            default: r_next.rdata = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= RST_STATE;
      end else begin
         r_reg <= r_next;
      end
   end

   assign rd_data       = r_reg.rdata;
   assign gate_value    = r_reg.active;
   assign wdt_reset_req = r_reg.rst_req;
   assign wdt_wake_req  = r_reg.wake_req;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_free_run;
      @(posedge sys_clk) disable iff (!nrst)
      (!r_reg.gate_en && r_reg.cnt_on && counter_clock_source &&
       !wr_strobe) |=> r_reg.count == $past(r_reg.count) + 1'b1;
   endproperty
   a_free_run: assert property (p_free_run)
      else $error("free-running counter did not advance");

   property p_gate_hold;
      @(posedge sys_clk) disable iff (!nrst)
      (r_reg.gate_en && !gate_open && !wr_strobe)
      |=> $stable(r_reg.count);
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("count moved while gate closed");

   property p_pol_low;
      @(posedge sys_clk) disable iff (!nrst)
      (r_reg.gate_en && !r_reg.gate_tog && !r_reg.gate_pol &&
       r_reg.gate_sel == SRC_PIN && !gate_input_pin && r_reg.cnt_on &&
       counter_clock_source && !wr_strobe)
      |=> r_reg.count != $past(r_reg.count);
   endproperty
   a_pol_low: assert property (p_pol_low)
      else $error("low gate with polarity 0 did not count");

   property p_comp_wrap;
      @(posedge sys_clk) disable iff (!nrst)
      (companion_tick && r_reg.comp == COMP_MAX && !wr_strobe)
      |=> r_reg.comp == 8'h00 ##0 r_reg.comp_ovf ##1 !r_reg.comp_ovf;
   endproperty
   a_comp_wrap: assert property (p_comp_wrap)
      else $error("companion wrap gave no single pulse");

   property p_wdt_on;
      @(posedge sys_clk) disable iff (!nrst)
      // Seen through the status word, not the run net itself
      (rd_strobe && addr == OFS_STATUS && r_reg.gate_en &&
       r_reg.gate_sel == SRC_WDT) |=> rd_data[ST_RUN_BIT];
   endproperty
   a_wdt_on: assert property (p_wdt_on)
      else $error("watchdog not running for watchdog gate");

   property p_no_reset;
      @(posedge sys_clk) disable iff (!nrst)
      (wdt_reset_req || wdt_wake_req) |-> $past(wdt_config_en);
   endproperty
   a_no_reset: assert property (p_no_reset)
      else $error("gate-only watchdog raised reset or wake");

   property p_toggle;
      @(posedge sys_clk) disable iff (!nrst)
      (r_reg.gate_tog && src_rise && !wr_strobe)
      |=> r_reg.tog != $past(r_reg.tog);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("toggle gate missed a source edge");

   property p_src_per;
      @(posedge sys_clk) disable iff (!nrst)
      (r_reg.gate_tog && r_reg.gate_pol && r_reg.gate_sel == SRC_PER &&
       ev.per_match && !r_reg.adj_prev && !wr_strobe)
      |=> r_reg.tog != $past(r_reg.tog);
   endproperty
   a_src_per: assert property (p_src_per)
      else $error("period match did not reach the gate");

endmodule
`default_nettype wire

// *** rtl/tgce_period.sv ***
// Period-match timer that wraps to zero after matching its limit.
// Assumes tick is a one-cycle enable from the core.
`timescale 1ns/1ps
`default_nettype none
module tgce_period
   import tgce_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic nrst,
   tgce_evt_if.per   ev
);
   typedef struct packed {
      logic [7:0] cnt;
      logic       match;
   } tgce_per_t;

   tgce_per_t r_reg, r_next;

   always_comb begin
      r_next       = r_reg;
      r_next.match = 1'b0;
      if (ev.per_wr) begin
         r_next.cnt = ev.per_wdata;
      end else if (ev.per_tick) begin
         if (r_reg.cnt == ev.per_limit) begin
            r_next.cnt   = 8'h00;
            r_next.match = 1'b1;
         end else begin
            r_next.cnt = r_reg.cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign ev.per_count = r_reg.cnt;
   assign ev.per_match = r_reg.match;

   property p_per_wrap;
      @(posedge sys_clk) disable iff (!nrst)
      (ev.per_tick && !ev.per_wr && r_reg.cnt == ev.per_limit)
      |=> (r_reg.cnt == 8'h00) && r_reg.match;
   endproperty
   a_per_wrap: assert property (p_per_wrap)
      else $error("period timer did not wrap with a pulse");

endmodule
`default_nettype wire

// *** rtl/tgce_pkg.sv ***
// Constants, encodings and reset values for the timer gate block.
// Assumes a 16-bit register port with a 3-bit word index.
package tgce_pkg;

   // ------------------------------------------------------------
   // Register port geometry and word indices
   // ------------------------------------------------------------
   localparam int         ADDR_W        = 3;
   localparam int         DATA_W        = 16;
   localparam logic [2:0] OFS_GATE_CTRL = 3'h0;
   localparam logic [2:0] OFS_CNT_CTRL  = 3'h1;
   localparam logic [2:0] OFS_COUNT     = 3'h2;
   localparam logic [2:0] OFS_COMP      = 3'h3;
   localparam logic [2:0] OFS_PER_CNT   = 3'h4;
   localparam logic [2:0] OFS_PER_LIM   = 3'h5;
   localparam logic [2:0] OFS_OPTION    = 3'h6;
   localparam logic [2:0] OFS_STATUS    = 3'h7;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int GC_EN_BIT   = 7;
   localparam int GC_POL_BIT  = 6;
   localparam int GC_TOG_BIT  = 5;
   localparam int GC_VAL_BIT  = 2;
   localparam int GC_SEL_LO   = 0;
   localparam int CC_ON_BIT   = 0;
   localparam int OPT_PSA_BIT = 3;
   localparam int OPT_PS_LO   = 0;
   localparam int ST_RUN_BIT  = 0;
   localparam int ST_SLP_BIT  = 1;

   // ------------------------------------------------------------
   // Reset values and timing counts
   // ------------------------------------------------------------
   localparam logic       OPT_PSA_RST   = 1'b1;
   localparam logic [2:0] OPT_PS_RST    = 3'h7;
   localparam logic [7:0] PER_LIM_RST   = 8'hFF;
   localparam logic [7:0] COMP_MAX      = 8'hFF;
   localparam int         CNT_W_DEF     = 16;
   localparam int         WDT_BASE_W    = 8;
   localparam int         WDT_OSC_DIV   = 64;

   typedef enum logic [1:0] {
      SRC_PIN  = 2'b00,
      SRC_COMP = 2'b01,
      SRC_PER  = 2'b10,
      SRC_WDT  = 2'b11
   } tgce_src_t;

endpackage

// *** rtl/tgce_wdt.sv ***
// Watchdog oscillator divider, prescaler and counter.
// Assumes run and clear come from the gate core each cycle.
`timescale 1ns/1ps
`default_nettype none
module tgce_wdt
   import tgce_pkg::*;
#(
   parameter int OSC_DIV = WDT_OSC_DIV,
   parameter int BASE_W  = WDT_BASE_W
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   tgce_evt_if.wdt   ev
);
   typedef struct packed {
      logic [15:0]       osc;
      logic [7:0]        pre;
      logic [BASE_W-1:0] base;
      logic              ovf;
   } tgce_wdt_t;

   tgce_wdt_t r_reg, r_next;
   logic      osc_tick;
   logic      pre_step;
   logic [7:0] mask;

   always_comb begin
      r_next   = r_reg;
      r_next.ovf = 1'b0;
      osc_tick = (r_reg.osc == 16'(OSC_DIV - 1));
      mask     = (8'h01 << ev.wdt_ps) - 8'h01;
      pre_step = !ev.wdt_psa || ((r_reg.pre & mask) == mask);
      if (!ev.wdt_run || ev.wdt_clr) begin
         r_next.osc  = '0;
         r_next.pre  = '0;
         r_next.base = '0;
      end else begin
         r_next.osc = osc_tick ? 16'h0000 : r_reg.osc + 16'h0001;
         if (osc_tick) begin
            r_next.pre = r_reg.pre + 8'h01;
            if (pre_step) begin
               r_next.base = BASE_W'(r_reg.base + 1'b1);
               r_next.ovf  = &r_reg.base;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign ev.wdt_ovf = r_reg.ovf;

   property p_wdt_clear;
      @(posedge sys_clk) disable iff (!nrst)
      ev.wdt_clr |=> (r_reg.base == '0) && (r_reg.pre == '0);
   endproperty
   a_wdt_clear: assert property (p_wdt_clear)
      else $error("watchdog not restarted by clear");

endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the timer gate block.
// Assumes one clock; register port answers one cycle after a read.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
   n_errors++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module tb_top;
   import tgce_pkg::*;
   // ------------------------------------------------------------
   // Signals and state
   // ------------------------------------------------------------
   localparam int     OSC = 2;
   logic              sys_clk, nrst, wr_strobe, rd_strobe, ccs;
   logic              wclr, slp_in, slp_out, cfg_en, pin_lvl;
   logic              comp_req, per_req, pin, ctick, ptick;
   logic              gate_value, rst_req, wake_req;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wr_data, rd_data, rv;
   logic [31:0]       seed;
   logic [15:0]       rst_exp [8];
   int                n_errors, checks_done, exp_cnt, n, t, n_req;

   tgce_gate #(.CNT_W(16), .OSC_DIV(OSC)) DUT (
      .sys_clk(sys_clk), .nrst(nrst), .addr(addr), .wr_data(wr_data),
      .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
      .gate_input_pin(pin), .counter_clock_source(ccs),
      .companion_tick(ctick), .period_tick(ptick),
      .watchdog_clear_op(wclr), .sleep_enter(slp_in),
      .sleep_wake(slp_out), .wdt_config_en(cfg_en),
      .gate_value(gate_value), .wdt_reset_req(rst_req),
      .wdt_wake_req(wake_req));
   tgce_src_model src (
      .sys_clk(sys_clk), .pin_lvl(pin_lvl), .comp_req(comp_req),
      .per_req(per_req), .gate_input_pin(pin),
      .companion_tick(ctick), .period_tick(ptick));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic stop_test();
      if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Gap cycle after each strobe keeps one assignment per time step
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      addr <= a; wr_data <= d; wr_strobe <= 1'b1;
      @(posedge sys_clk); wr_strobe <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [2:0] a, output logic [15:0] d);
      addr <= a; rd_strobe <= 1'b1;
      @(posedge sys_clk); rd_strobe <= 1'b0;
      #1 d = rd_data;
      @(posedge sys_clk);
   endtask
   // Clearing first drops any stale toggle state
   task automatic setgc(input logic [15:0] d);
      wr(OFS_GATE_CTRL, 16'h0000);
      wr(OFS_GATE_CTRL, d);
   endtask
   task automatic clocks(input int k);
      repeat (k) begin ccs <= 1'b1; @(posedge sys_clk); end
      ccs <= 1'b0; @(posedge sys_clk);
   endtask
   task automatic wait_tog(output int tc);
      logic g0;
      g0 = gate_value; tc = 0;
      while (gate_value === g0 && tc < 3000) begin
         @(posedge sys_clk); tc++;
      end
      if (tc >= 3000) begin
         `CHK("gate wait", 1'b1, 1'b0)
         stop_test();
      end
   endtask
   always @(posedge sys_clk) if (rst_req === 1'b1 || wake_req === 1'b1)
      n_req++;

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {nrst, wr_strobe, rd_strobe, ccs, wclr, slp_in, slp_out} = '0;
      {cfg_en, pin_lvl, comp_req, per_req} = '0;
      addr = '0; wr_data = '0; seed = 32'h699a;
      n_errors = 0; checks_done = 0; n_req = 0;
      // Pin 0 with polarity 0 reads back as an open gate
      rst_exp = '{16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                  16'h00FF, 16'h000F, 16'h0000};
      repeat (8) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         rd(3'(i), rv); `CHK("reset word", rst_exp[i], rv)
      end
      wr(OFS_CNT_CTRL, 16'h0001);
      exp_cnt = rnd() & 16'hFFFF;
      wr(OFS_COUNT, 16'(exp_cnt));
      pin_lvl <= 1'(rnd());
      n = rnd() % 20 + 1; clocks(n); exp_cnt += n;
      rd(OFS_COUNT, rv); `CHK("count", 16'(exp_cnt), rv)
      // level gate from pin, both senses
      for (int p = 0; p < 2; p++) for (int l = 0; l < 2; l++) begin
         wr(OFS_GATE_CTRL, 16'(16'h0080 | (p << 6)));
         pin_lvl <= l[0]; repeat (3) @(posedge sys_clk);
         n = rnd() % 8 + 1; clocks(n);
         if (l == p) exp_cnt += n;
         rd(OFS_COUNT, rv); `CHK("count", 16'(exp_cnt), rv)
      end
      rd(OFS_STATUS, rv); `CHK("status", 16'h0000, rv)
      // companion wrap toggles gate; non-wrap tick does not
      setgc(16'h00E1);
      for (int k = 0; k < 3; k++) begin
         if (k != 1) wr(OFS_COMP, 16'h00FF);
         comp_req <= 1'b1; @(posedge sys_clk); comp_req <= 1'b0;
         repeat (5) @(posedge sys_clk);
         `CHK("gate", 1'(k < 2), gate_value)
      end
      rd(OFS_COMP, rv); `CHK("companion", 16'h0000, rv)
      // period timer wraps to zero with the match pulse on the tick at its limit
      setgc(16'h00E2); wr(OFS_PER_LIM, 16'h0002);
      wr(OFS_PER_CNT, 16'h0000);
      for (int k = 1; k < 4; k++) begin
         per_req <= 1'b1; @(posedge sys_clk); per_req <= 1'b0;
         repeat (5) @(posedge sys_clk);
         rd(OFS_PER_CNT, rv); `CHK("period count", 16'(k % 3), rv)
         `CHK("gate", 1'(k == 3), gate_value)
      end
      // watchdog source in toggle mode, counter off
      wr(OFS_CNT_CTRL, 16'h0000); setgc(16'h00E3);
      rd(OFS_STATUS, rv); `CHK("status", 16'h0001, rv)
      wr(OFS_OPTION, 16'h0000);
      wait_tog(t); wait_tog(t); `CHK("interval", 32'(OSC * 256), t)
      // first interval after a change is not judged
      wr(OFS_OPTION, 16'h0009);
      wait_tog(t); wait_tog(t); `CHK("interval", 32'(OSC * 512), t)
      // each clear kind restarts the interval
      for (int k = 0; k < 3; k++) begin
         wait_tog(t); repeat (300) @(posedge sys_clk);
         case (k)
            0: wclr <= 1'b1;
            1: slp_in <= 1'b1;
            default: slp_out <= 1'b1;
         endcase
         @(posedge sys_clk); {wclr, slp_in, slp_out} <= '0;
         wait_tog(t);
         `CHK("restart", 1'b1, t > OSC * 510 && t < OSC * 514)
      end
      // gate use alone raises no reset or wake
      `CHK("wdt requests", 0, n_req)
      cfg_en <= 1'b1; t = 0;
      while (n_req == 0 && t < 1200) begin @(posedge sys_clk); t++; end
      `CHK("wdt reset", 1'b1, n_req > 0)
      // Overflow while asleep must come out as a wake request
      slp_in <= 1'b1; @(posedge sys_clk); slp_in <= 1'b0; t = 0;
      while (wake_req !== 1'b1 && t < 1200) begin
         @(posedge sys_clk); t++;
      end
      `CHK("wdt wake", 1'b1, wake_req)
      stop_test();
   end
endmodule
`default_nettype wire

// *** sim/tgce_src_model.sv ***
// Far-side source model: external gate pin and timer tick requests.
// Assumes the bench sets requests just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module tgce_src_model (
   input  wire logic sys_clk,
   input  wire logic pin_lvl,
   input  wire logic comp_req,
   input  wire logic per_req,
   output logic      gate_input_pin,
   output logic      companion_tick,
   output logic      period_tick
);
   // ------------------------------------------------------------
   // Source drivers
   // ------------------------------------------------------------
   initial begin
      gate_input_pin = 1'b0;
      companion_tick = 1'b0;
      period_tick    = 1'b0;
   end
   always @(posedge sys_clk) begin
      gate_input_pin <= pin_lvl;
      companion_tick <= comp_req;
      period_tick    <= per_req;
   end
endmodule
`default_nettype wire
